// ===== hdl/pafs_pkg.sv
package pafs_pkg;
   // Bus geometry
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned REG_W    = 16;
   localparam int unsigned PIN_CNT  = 16;

   // Register byte offsets
   localparam logic [7:0] OFF_BASE_MODE_LOW = 8'h00;
   localparam logic [7:0] OFF_ALT_LOWER     = 8'h04;
   localparam logic [7:0] OFF_ALT_LOW_MID   = 8'h08;
   localparam logic [7:0] OFF_ALT_HIGH_MID  = 8'h0C;
   localparam logic [7:0] OFF_ALT_UPPER     = 8'h10;
   localparam logic [7:0] OFF_DIRECTION     = 8'h14;
   localparam logic [7:0] OFF_PORT_DATA     = 8'h18;
   localparam logic [7:0] OFF_PIN_LEVEL     = 8'h1C;
   localparam logic [7:0] OFF_FUNC_STATUS   = 8'h20;

   // Mode field positions inside each mode register
   localparam int unsigned POS_SEL3 = 12;
   localparam int unsigned POS_SEL2 = 8;
   localparam int unsigned POS_SEL1 = 4;
   localparam int unsigned POS_SEL0 = 0;

   // Writable bits of a mode register; all others reserved
   localparam logic [15:0] MODE_MASK = 16'h1111;
   localparam logic [15:0] FULL_MASK = 16'hFFFF;

   // Reset values
   localparam logic [15:0] RST_BASE_MODE = 16'h0000;
   localparam logic [15:0] RST_ALT_MODE  = 16'h0000;
   localparam logic [15:0] RST_DIRECTION = 16'h0000;
   localparam logic [15:0] RST_PORT_DATA = 16'h0000;

   // Mode register to four pin select bits, pin 4k at bit 0
   function automatic logic [3:0] pafs_gather(input logic [15:0] r);
      pafs_gather = {r[POS_SEL3], r[POS_SEL2], r[POS_SEL1], r[POS_SEL0]};
   endfunction

   // Byte-lane write merge with reserved bits forced to zero
   function automatic logic [15:0] pafs_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb,
                                              input logic [15:0] mask);
      logic [15:0] v;
      v        = old;
      if (strb[0]) v[7:0]  = wd[7:0];
      if (strb[1]) v[15:8] = wd[15:8];
      pafs_merge = v & mask;
   endfunction
endpackage

// ===== hdl/pafs_pin_select.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Contract
// - Base mode bits 12 and 8 belong to pins 3 and 2, leave them as port pins, and reset to 0.
// - Base mode bits 4 and 0 belong to pins 1 and 0, leave them as port pins, and reset to 0.
// - Reserved groups 15-13, 11-9, 7-5 and 3-1 of every mode register read as zero and get zero.
// - Each of the four alternate mode registers is a 16-bit read/write register.
// - Power-on reset, hardware standby and watchdog reset clear all alternate registers.
// - Sleep mode leaves the alternate registers unchanged.
// - Upper alternate bits 12, 8, 4, 0 route pins 15, 14, 13, 12 to timer channels 33..30.
// - High-mid alternate bits 12, 8, 4, 0 route pins 11, 10, 9, 8 to timer channels 23..20.
// - Low-mid alternate bits 12, 8, 4, 0 route pins 7, 6, 5, 4 to timer channels 13..10.
// - Lower alternate bits 12, 8, 4 route pins 3, 2, 1 to timer channels 03, 02, 01.
// - A timer function is chosen only when the base bit is 0 and the alternate bit is 1.
// - An alternate bit of 0 leaves its pin as a general port pin.
// - Lower alternate bit 0 routes pin 0 to timer channel 00 while its base bit is 0.
// - A port pin drives when its direction bit is 1, and the bit is ignored in timer mode.
module pafs_pin_select
   import pafs_pkg::*;
#(
   parameter int unsigned PINS = pafs_pkg::PIN_CNT
) (
   // Clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   // Extra clear sources and low-power state
   input  wire logic                         standby_entry,
   input  wire logic                         wdt_por_req,
   input  wire logic                         sleep_mode,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [pafs_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [pafs_pkg::DATA_W-1:0]  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [pafs_pkg::DATA_W-1:0]  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Base mode bits of pins 15..4 from the upper base registers
   input  wire logic [15:4]                  base_sel_hi,
   // Timer channel side, bit i is the channel sharing pin i
   input  wire logic [15:0]                  timer_ch_io_out,
   input  wire logic [15:0]                  timer_ch_io_oe,
   output logic      [15:0]                  timer_ch_io_in,
   output logic      [15:0]                  timer_ch_sel,
   // Pin pads
   input  wire logic [15:0]                  pad_in,
   output logic      [15:0]                  pad_out,
   output logic      [15:0]                  pad_oe_n
);
   import pafs_pkg::*;

   if (PINS != 16) begin : g_pins_check
      $error("pafs_pin_select serves exactly sixteen pins");
   end

   logic [15:0] base_q;
   logic [15:0] alt_lower_q;
   logic [15:0] alt_low_mid_q;
   logic [15:0] alt_high_mid_q;
   logic [15:0] alt_upper_q;
   logic [15:0] dir_q;
   logic [15:0] data_q;
   logic [15:0] pin_q;
   logic [15:0] pad_out_q;
   logic [15:0] pad_oe_n_q;
   logic [15:0] tmr_in_q;
   logic [15:0] tmr_sel_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   // Bus phase decode
   wire         acc      = psel & penable;
   wire         rd_cap   = acc & ~pready_q;
   wire         wr_en    = acc & pready_q & pwrite;
   wire         clr      = standby_entry | wdt_por_req;

   wire         sel_base = (paddr == OFF_BASE_MODE_LOW);
   wire         sel_a1   = (paddr == OFF_ALT_LOWER);
   wire         sel_a2   = (paddr == OFF_ALT_LOW_MID);
   wire         sel_a3   = (paddr == OFF_ALT_HIGH_MID);
   wire         sel_a4   = (paddr == OFF_ALT_UPPER);
   wire         sel_dir  = (paddr == OFF_DIRECTION);
   wire         sel_dat  = (paddr == OFF_PORT_DATA);
   wire         sel_pin  = (paddr == OFF_PIN_LEVEL);
   wire         sel_fst  = (paddr == OFF_FUNC_STATUS);
   wire         hit      = sel_base | sel_a1 | sel_a2 | sel_a3 | sel_a4 |
                           sel_dir | sel_dat | sel_pin | sel_fst;

   // Next register values, reserved bits masked off
   wire  [15:0] base_w   = pafs_merge(base_q, pwdata, pstrb, MODE_MASK);
   wire  [15:0] a1_w     = pafs_merge(alt_lower_q, pwdata, pstrb, MODE_MASK);
   wire  [15:0] a2_w     = pafs_merge(alt_low_mid_q, pwdata, pstrb, MODE_MASK);
   wire  [15:0] a3_w     = pafs_merge(alt_high_mid_q, pwdata, pstrb, MODE_MASK);
   wire  [15:0] a4_w     = pafs_merge(alt_upper_q, pwdata, pstrb, MODE_MASK);
   wire  [15:0] dir_w    = pafs_merge(dir_q, pwdata, pstrb, FULL_MASK);
   wire  [15:0] dat_w    = pafs_merge(data_q, pwdata, pstrb, FULL_MASK);

   // Effective per-pin selects
   wire  [15:0] base_eff = {base_sel_hi, pafs_gather(base_q)};
   wire  [15:0] alt_eff  = {pafs_gather(alt_upper_q),
                            pafs_gather(alt_high_mid_q),
                            pafs_gather(alt_low_mid_q),
                            pafs_gather(alt_lower_q)};
   wire  [15:0] tmr_sel  = ~base_eff & alt_eff;

   // Pad drive: timer channel or port data, direction only in port mode
   wire  [15:0] pad_o_d  = (tmr_sel & timer_ch_io_out) | (~tmr_sel & data_q);
   wire  [15:0] pad_oe_d = ~((tmr_sel & timer_ch_io_oe) | (~tmr_sel & dir_q));
   wire  [15:0] tmr_in_d = tmr_sel & pad_in;

   // Read mux, narrow registers in the low half
   wire  [15:0] rd_mux   = sel_base ? base_q         :
                           sel_a1   ? alt_lower_q    :
                           sel_a2   ? alt_low_mid_q  :
                           sel_a3   ? alt_high_mid_q :
                           sel_a4   ? alt_upper_q    :
                           sel_dir  ? dir_q          :
                           sel_dat  ? data_q         :
                           sel_pin  ? pin_q          :
                           sel_fst  ? tmr_sel_q      : 16'h0000;

   // APB answer: one wait state, error on unmapped address
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= rd_cap;
         pslverr_q <= rd_cap & ~hit;
         if (rd_cap) begin
            prdata_q <= (hit && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   // Mode registers: cleared by reset, standby or watchdog, kept in sleep
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q         <= RST_BASE_MODE;
         alt_lower_q    <= RST_ALT_MODE;
         alt_low_mid_q  <= RST_ALT_MODE;
         alt_high_mid_q <= RST_ALT_MODE;
         alt_upper_q    <= RST_ALT_MODE;
      end else if (clr) begin
         base_q         <= RST_BASE_MODE;
         alt_lower_q    <= RST_ALT_MODE;
         alt_low_mid_q  <= RST_ALT_MODE;
         alt_high_mid_q <= RST_ALT_MODE;
         alt_upper_q    <= RST_ALT_MODE;
      end else if (wr_en) begin
         if (sel_base) base_q         <= base_w;
         if (sel_a1)   alt_lower_q    <= a1_w;
         if (sel_a2)   alt_low_mid_q  <= a2_w;
         if (sel_a3)   alt_high_mid_q <= a3_w;
         if (sel_a4)   alt_upper_q    <= a4_w;
      end
   end

   // Port direction and data
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_q  <= RST_DIRECTION;
         data_q <= RST_PORT_DATA;
      end else if (clr) begin
         dir_q  <= RST_DIRECTION;
         data_q <= RST_PORT_DATA;
      end else if (wr_en) begin
         if (sel_dir) dir_q  <= dir_w;
         if (sel_dat) data_q <= dat_w;
      end
   end

   // Registered pad and timer side
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_out_q  <= 16'h0000;
         pad_oe_n_q <= 16'hFFFF;
         tmr_in_q   <= 16'h0000;
         tmr_sel_q  <= 16'h0000;
         pin_q      <= 16'h0000;
      end else begin
         pad_out_q  <= pad_o_d;
         pad_oe_n_q <= pad_oe_d;
         tmr_in_q   <= tmr_in_d;
         tmr_sel_q  <= tmr_sel;
         pin_q      <= pad_in;
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign pad_out        = pad_out_q;
   assign pad_oe_n       = pad_oe_n_q;
   assign timer_ch_io_in = tmr_in_q;
   assign timer_ch_sel   = tmr_sel_q;

   // Checks
   property p_base_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && sel_base && !clr && pstrb == 4'hF)
         |=> (base_q == ($past(pwdata[15:0]) & MODE_MASK));
   endproperty
   a_base_write: assert property (p_base_write)
      else $error("base mode register write not stored as masked data");

   property p_reserved_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_cap && !pwrite && (sel_base || sel_a1 || sel_a2 || sel_a3 || sel_a4))
         |=> pready_q && ((prdata_q[15:0] & ~MODE_MASK) == 16'h0000);
   endproperty
   a_reserved_read: assert property (p_reserved_read)
      else $error("reserved mode bits read nonzero");

   property p_alt_rw;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_cap && !pwrite && sel_a2) |=> prdata_q[15:0] == $past(alt_low_mid_q);
   endproperty
   a_alt_rw: assert property (p_alt_rw)
      else $error("alternate register read back differs");

   property p_alt_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && sel_a4 && !clr && pstrb == 4'hF)
         |=> (alt_upper_q == ($past(pwdata[15:0]) & MODE_MASK));
   endproperty
   a_alt_write: assert property (p_alt_write)
      else $error("alternate register write not stored as masked data");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      clr |=> (alt_lower_q | alt_low_mid_q | alt_high_mid_q | alt_upper_q) == 16'h0000
              && tmr_sel == 16'h0000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("alternate registers not cleared");

   property p_sleep_keep;
      @(posedge ref_clk) disable iff (!rst_n)
      (sleep_mode && !clr && !wr_en)
         |=> $stable(alt_lower_q) && $stable(alt_low_mid_q)
             && $stable(alt_high_mid_q) && $stable(alt_upper_q);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep)
      else $error("alternate registers changed in sleep");

   property p_route_upper;
      @(posedge ref_clk) disable iff (!rst_n)
      (alt_upper_q[POS_SEL3] && !base_sel_hi[15])
         |=> pad_out_q[15] == $past(timer_ch_io_out[15]) && timer_ch_sel[15];
   endproperty
   a_route_upper: assert property (p_route_upper)
      else $error("pin 15 not routed to timer channel 33");

   property p_route_high_mid;
      @(posedge ref_clk) disable iff (!rst_n)
      (alt_high_mid_q[POS_SEL0] && !base_sel_hi[8])
         |=> timer_ch_io_in[8] == $past(pad_in[8]);
   endproperty
   a_route_high_mid: assert property (p_route_high_mid)
      else $error("pin 8 not routed to timer channel 20");

   property p_route_low_mid;
      @(posedge ref_clk) disable iff (!rst_n)
      (alt_low_mid_q[POS_SEL2] && !base_sel_hi[6])
         |=> pad_oe_n_q[6] == !$past(timer_ch_io_oe[6]);
   endproperty
   a_route_low_mid: assert property (p_route_low_mid)
      else $error("pin 6 not routed to timer channel 12");

   property p_route_lower;
      @(posedge ref_clk) disable iff (!rst_n)
      (alt_lower_q[POS_SEL1] && !base_q[POS_SEL1])
         |=> pad_out_q[1] == $past(timer_ch_io_out[1]);
   endproperty
   a_route_lower: assert property (p_route_lower)
      else $error("pin 1 not routed to timer channel 01");

   property p_base_blocks;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (timer_ch_sel & $past(base_eff)) == 16'h0000
               && timer_ch_sel == ($past(alt_eff) & ~$past(base_eff));
   endproperty
   a_base_blocks: assert property (p_base_blocks)
      else $error("timer selected against base mode bit");

   property p_port_mode;
      @(posedge ref_clk) disable iff (!rst_n)
      !alt_eff[5] |=> !timer_ch_sel[5] && pad_out_q[5] == $past(data_q[5])
                      && timer_ch_io_in[5] == 1'b0;
   endproperty
   a_port_mode: assert property (p_port_mode)
      else $error("pin 5 not in port mode with alternate bit clear");

   property p_route_pin0;
      @(posedge ref_clk) disable iff (!rst_n)
      (alt_lower_q[POS_SEL0] && !base_q[POS_SEL0])
         |=> timer_ch_sel[0] && timer_ch_io_in[0] == $past(pad_in[0]);
   endproperty
   a_route_pin0: assert property (p_route_pin0)
      else $error("pin 0 not routed to timer channel 00");

   property p_direction;
      @(posedge ref_clk) disable iff (!rst_n)
      !tmr_sel[2] |=> pad_oe_n_q[2] == !$past(dir_q[2]);
   endproperty
   a_direction: assert property (p_direction)
      else $error("port pin direction not honoured");

   property p_reserved_drop;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && sel_a3) |=> (alt_high_mid_q & ~MODE_MASK) == 16'h0000;
   endproperty
   a_reserved_drop: assert property (p_reserved_drop)
      else $error("reserved bit written");

   property p_apb_wait;
      @(posedge ref_clk) disable iff (!rst_n)
      (psel && !penable) ##1 (psel && penable) |=> pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("APB answer not after one wait state");

   property p_unmapped;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_cap && !hit) |=> pready_q && pslverr_q && prdata_q == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   c_timer_pin: cover property (@(posedge ref_clk) disable iff (!rst_n)
      timer_ch_sel[15] ##1 !timer_ch_sel[15]);
   c_alt_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en && sel_a1 && pwdata[0]);
   c_unmapped: cover property (@(posedge ref_clk) disable iff (!rst_n)
      pready && pslverr);
   c_base_block: cover property (@(posedge ref_clk) disable iff (!rst_n)
      alt_eff[2] && base_eff[2]);
   c_sleep_hold: cover property (@(posedge ref_clk) disable iff (!rst_n)
      sleep_mode && alt_lower_q != 16'h0000);
endmodule

// ===== test/pafs_timer_model.sv
`timescale 1ns/1ps
// Timer channels and the board side of the port pins
module pafs_timer_model (
   // Levels chosen by the bench
   input  wire logic [15:0] tmr_val,
   input  wire logic [15:0] tmr_en,
   input  wire logic [15:0] ext_lvl,
   // Timer side of the block
   output logic      [15:0] timer_ch_io_out,
   output logic      [15:0] timer_ch_io_oe,
   // Pad wires
   input  wire logic [15:0] pad_out,
   input  wire logic [15:0] pad_oe_n,
   output logic      [15:0] pad_in
);
   assign timer_ch_io_out = tmr_val;
   assign timer_ch_io_oe  = tmr_en;
   // Block driver wins, else the board level
   assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_lvl);
endmodule

// ===== test/port_a_pin_function_select_test.sv
`timescale 1ns/1ps
module port_a_pin_function_select_test;
   import pafs_pkg::*;
   logic              ref_clk, rst_n, standby_entry, wdt_por_req, sleep_mode;
   logic              psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic [15:4]       base_sel_hi;
   logic [15:0]       timer_ch_io_out, timer_ch_io_oe, timer_ch_io_in, timer_ch_sel;
   logic [15:0]       pad_in, pad_out, pad_oe_n, tmr_val, tmr_en, ext_lvl;
   logic [15:0]       alt [4];
   logic [15:0]       base_lo, dir, pdat, sel, exp_out, exp_oen;
   logic [33:0]       expq [$];
   logic [33:0]       e;
   int                n_errors, num_checks, cyc;
   localparam logic [7:0] ALT_OFF [4] = '{OFF_ALT_LOWER, OFF_ALT_LOW_MID,
                                          OFF_ALT_HIGH_MID, OFF_ALT_UPPER};

   pafs_pin_select dut (.ref_clk, .rst_n, .standby_entry, .wdt_por_req, .sleep_mode,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .base_sel_hi, .timer_ch_io_out, .timer_ch_io_oe, .timer_ch_io_in, .timer_ch_sel,
      .pad_in, .pad_out, .pad_oe_n);

   pafs_timer_model far (.tmr_val, .tmr_en, .ext_lvl, .timer_ch_io_out, .timer_ch_io_oe,
      .pad_out, .pad_oe_n, .pad_in);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, want);
      end
   endtask

   // One APB transfer; the note is queued at setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] rexp, input logic err);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      expq.push_back({~w, err, rexp});
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0, want, 1'b0);
   endtask

   // Response watcher
   always @(posedge ref_clk) begin
      if (rst_n && psel && penable && pready === 1'b1) begin
         e = expq.pop_front();
         chk({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) chk(prdata, e[31:0]);
      end
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         summarize;
      end
   end

   task automatic chk_pins;
      logic [15:0] altv, basev, lvl;
      for (int i = 0; i < 16; i++) altv[i] = alt[i/4][4*(i%4)];
      basev   = {base_sel_hi, base_lo[12], base_lo[8], base_lo[4], base_lo[0]};
      sel     = altv & ~basev;
      exp_out = (sel & tmr_val) | (~sel & pdat);
      exp_oen = ~((sel & tmr_en) | (~sel & dir));
      lvl     = (~exp_oen & exp_out) | (exp_oen & ext_lvl);
      repeat (4) @(posedge ref_clk);
      chk(timer_ch_sel, sel);
      chk(pad_out, exp_out);
      chk(pad_oe_n, exp_oen);
      chk(timer_ch_io_in, lvl & sel);
      rd(OFF_FUNC_STATUS, {16'h0, sel});
      rd(OFF_PIN_LEVEL, {16'h0, lvl});
   endtask

   initial begin
      {rst_n, standby_entry, wdt_por_req, sleep_mode, psel, penable, pwrite} = '0;
      {paddr, pwdata, base_sel_hi, tmr_val, tmr_en, ext_lvl} = '0;
      {base_lo, dir, pdat} = '0;
      pstrb = 4'hF;
      n_errors = 0;
      num_checks = 0;
      cyc = 0;
      for (int k = 0; k < 4; k++) alt[k] = 16'h0;
      void'($urandom(32'h8d70));
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(OFF_BASE_MODE_LOW, 32'h0);
      for (int k = 0; k < 4; k++) rd(ALT_OFF[k], 32'h0);
      chk_pins;
      $display("test reset values done");
      for (int it = 0; it < 8; it++) begin
         for (int k = 0; k < 4; k++) alt[k] = it == 0 ? 16'hFFFF : 16'($urandom);
         base_lo = it == 1 ? 16'hFFFF : it == 0 ? 16'h0 : 16'($urandom);
         dir  = 16'($urandom);
         pdat = 16'($urandom);
         base_sel_hi <= it == 0 ? 12'h0 : it == 1 ? 12'hFFF : 12'($urandom);
         tmr_val <= 16'($urandom);
         tmr_en  <= 16'($urandom);
         ext_lvl <= 16'($urandom);
         wr(OFF_BASE_MODE_LOW, {16'hA5C3, base_lo});
         for (int k = 0; k < 4; k++) wr(ALT_OFF[k], {16'h5A3C, alt[k]});
         wr(OFF_DIRECTION, {16'h0, dir});
         wr(OFF_PORT_DATA, {16'h0, pdat});
         rd(OFF_BASE_MODE_LOW, {16'h0, base_lo & MODE_MASK});
         for (int k = 0; k < 4; k++) rd(ALT_OFF[k], {16'h0, alt[k] & MODE_MASK});
         rd(OFF_DIRECTION, {16'h0, dir});
         rd(OFF_PORT_DATA, {16'h0, pdat});
         chk_pins;
      end
      $display("test routing done");
      sleep_mode <= 1'b1;
      repeat (8) @(posedge ref_clk);
      for (int k = 0; k < 4; k++) rd(ALT_OFF[k], {16'h0, alt[k] & MODE_MASK});
      sleep_mode <= 1'b0;
      $display("test sleep retention done");
      for (int s = 0; s < 3; s++) begin
         for (int k = 0; k < 4; k++) wr(ALT_OFF[k], 32'h1111);
         wr(OFF_BASE_MODE_LOW, 32'h1111);
         @(posedge ref_clk);
         if (s == 0) standby_entry <= 1'b1;
         else if (s == 1) wdt_por_req <= 1'b1;
         else rst_n <= 1'b0;
         repeat (2) @(posedge ref_clk);
         standby_entry <= 1'b0;
         wdt_por_req   <= 1'b0;
         rst_n         <= 1'b1;
         for (int k = 0; k < 4; k++) rd(ALT_OFF[k], 32'h0);
         rd(OFF_BASE_MODE_LOW, 32'h0);
      end
      $display("test clear sources done");
      apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h28, 32'hFFFF, 32'h0, 1'b1);
      apb(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
      $display("test unmapped access done");
      @(posedge ref_clk);
      summarize;
   end
endmodule
